// ==== afe_controller_end.sv ====
/*
  Timing generator and image controller end of the front-end link.
  Makes line timing and strobes, sends serial frames and captures pixels.
  Assumes software on a plain register port; read data one cycle later.
*/
`timescale 1ns/1ps
`include "afe_defs.svh"
module afe_controller_end #(
  parameter int unsigned SETTLE_CYCLES = `SETTLE_CYC_DEF
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        nrst,
  // Link to the device.
  afe_link_if.controller   link,
  // Software register port.
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [15:0]      reg_rdata
);
  import afe_pkg::*;

  logic [4:0]  ctrl;
  logic [4:0]  next_ctrl;
  logic [15:0] frame;
  logic [15:0] next_frame;
  logic        pending;
  logic        next_pending;
  ser_state_t  ser_state;
  ser_state_t  next_ser_state;
  logic [2:0]  half_cnt;
  logic [2:0]  next_half_cnt;
  logic [4:0]  bit_cnt;
  logic [4:0]  next_bit_cnt;
  logic [2:0]  div;
  logic [2:0]  next_div;
  logic [5:0]  pix_cnt;
  logic [5:0]  next_pix_cnt;
  logic [1:0]  warm;
  logic [1:0]  next_warm;
  logic [25:0] settle;
  logic [25:0] next_settle;
  logic [8:0]  pins;
  logic [8:0]  next_pins;
  logic [15:0] last_pix;
  logic [15:0] next_last_pix;
  logic [15:0] next_rdata;
  logic        run;
  logic        busy;
  logic        ready;
  logic        settled;
  logic        half_end;
  logic [2:0]  pol;

  // Line timing, strobes, serial sender and register port.
  always_comb begin
    run      = ctrl[`CT_RUN];
    pol      = ctrl[`CT_POL_LO +: 3];
    ready    = !run || warm == `WARM_TICKS;                        // [R10]
    settled  = settle == 26'(SETTLE_CYCLES);                       // [R16]
    busy     = pending || ser_state != SER_IDLE;
    half_end = half_cnt == 3'(`SCLK_HALF_CYC - 1);
    next_div     = run ? div + 3'h1 : 3'h0;
    next_pix_cnt = !run ? 6'h00 : (div == `PIX_LAST) ? pix_cnt + 6'h01 : pix_cnt;
    next_warm    = warm;
    if (!run) begin
      next_warm = 2'h0;
    end else if (div == `PIX_LAST && warm != `WARM_TICKS) begin
      next_warm = warm + 2'h1;
    end
    next_settle = !run ? 26'h0 : settled ? settle : settle + 26'h1;
    next_pins[0] = run && div < `PIX_HIGH;
    next_pins[1] = (run && div == `REF_PHASE) ^ ~pol[2];
    next_pins[2] = (run && div == `DATA_PHASE) ^ ~pol[2];
    next_pins[3] = (run && pix_cnt < `DUMMY_END) ^ ~pol[0];        // [R3]
    next_pins[4] = (run && pix_cnt >= `DUMMY_END && pix_cnt < `BLACK_END) ^ ~pol[1]; // [R5]
    next_pins[5] = ctrl[`CT_CDS];
    next_pins[8:6] = pins[8:6];
    next_ser_state = ser_state;
    next_half_cnt  = half_end ? 3'h0 : half_cnt + 3'h1;
    next_bit_cnt   = bit_cnt;
    next_frame     = frame;
    next_pending   = pending;
    case (ser_state)
      SER_IDLE: begin
        next_half_cnt = 3'h0;
        if (pending && ready) begin                                // [R10]
          next_ser_state = SER_SHIFT;
          next_pending   = 1'b0;
          next_bit_cnt   = 5'h00;
          next_pins[8:6] = {1'b0, frame[15], 1'b0};                // [R17]
        end
      end
      SER_SHIFT: begin
        if (half_end) begin
          next_pins[6] = ~pins[6];
          if (pins[6]) begin
            next_bit_cnt = bit_cnt + 5'h01;
            next_frame   = {frame[14:0], 1'b0};
            next_pins[7] = frame[14];
            if (bit_cnt == 5'(`FRAME_BITS - 1)) begin
              next_ser_state = SER_LATCH;
            end
          end
        end
      end
      SER_LATCH: begin
        if (half_end) begin
          next_pins[8]   = 1'b1;                                   // [R17]
          next_ser_state = SER_IDLE;
        end
      end
      default: next_ser_state = SER_IDLE;
    endcase
    next_ctrl = ctrl;
    if (reg_write && reg_addr == `CR_CTRL) begin
      next_ctrl = reg_wdata[4:0];
    end
    // A frame that starts this cycle still shifts the old word, so refuse the write then.
    if (reg_write && reg_addr == `CR_FRAME && next_ser_state == SER_IDLE) begin
      next_frame   = reg_wdata;
      next_pending = 1'b1;
    end
    next_last_pix = link.pixel_valid ? {link.pixel_odd, 3'h0, link.pixel_data} : last_pix;
    next_rdata = 16'h0000;
    if (reg_read) begin
      case (reg_addr)
        `CR_FRAME:  next_rdata = frame;
        `CR_CTRL:   next_rdata = {11'h000, ctrl};
        `CR_STATUS: next_rdata = {13'h0000, ready, settled, busy};
        `CR_PIXEL:  next_rdata = last_pix;
        default:    next_rdata = 16'h0000;
      endcase
    end
  end

  // Registers only; the serial latch idles high between frames.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl      <= `CTRL_RESET;
      frame     <= 16'h0000;
      pending   <= 1'b0;
      ser_state <= SER_IDLE;
      half_cnt  <= 3'h0;
      bit_cnt   <= 5'h00;
      div       <= 3'h0;
      pix_cnt   <= 6'h00;
      warm      <= 2'h0;
      settle    <= 26'h0;
      pins      <= 9'h11e;
      last_pix  <= 16'h0000;
      reg_rdata <= 16'h0000;
    end else begin
      ctrl      <= next_ctrl;
      frame     <= next_frame;
      pending   <= next_pending;
      ser_state <= next_ser_state;
      half_cnt  <= next_half_cnt;
      bit_cnt   <= next_bit_cnt;
      div       <= next_div;
      pix_cnt   <= next_pix_cnt;
      warm      <= next_warm;
      settle    <= next_settle;
      pins      <= next_pins;
      last_pix  <= next_last_pix;
      reg_rdata <= next_rdata;
    end
  end

  assign link.pixel_system_clock       = pins[0];
  assign link.reference_sample_pulse   = pins[1];
  assign link.data_sample_pulse        = pins[2];
  assign link.input_clamp_strobe       = pins[3];
  assign link.black_level_clamp_strobe = pins[4];
  assign link.correlated_sample_select = pins[5];
  assign link.serial_clock             = pins[6];
  assign link.serial_data_in           = pins[7];
  assign link.serial_latch_strobe      = pins[8];
endmodule : afe_controller_end

// ==== afe_defs.svh ====
/*
  Constants shared by both ends of the line-sensor front-end link:
  serial frame layout, register addresses, field positions, reset values
  and timing counts. Assumes a 125 MHz system clock.
*/
`ifndef AFE_DEFS_SVH
`define AFE_DEFS_SVH

// System clock period.
`define CLOCK_PERIOD_NS 8

// Serial frame fields, most significant bit sent first.
`define FR_SEL_HI  15
`define FR_SEL_LO  14
`define FR_READ    13
`define FR_ADDR_HI 12
`define FR_ADDR_LO 10
`define FR_DATA_HI 9
`define FRAME_BITS 16

// Device register addresses.
`define RA_CONFIG  3'h0
`define RA_STANDBY 3'h1
`define RA_GAIN_E  3'h2
`define RA_GAIN_O  3'h3
`define RA_CLAMP_E 3'h4
`define RA_CLAMP_O 3'h5
`define RA_TEST    3'h6

// Configuration fields and writable-bit masks.
`define CFG_POL_CLAMP  0
`define CFG_POL_BLACK  1
`define CFG_POL_SAMPLE 2
`define CFG_ORDER      4
`define CFG_DLY_LO     6
`define CFG_DLY_HI     7
`define CFG_MASK       8'hd7
`define TST_EN         0
`define TST_STRIPE     2
`define TST_IVL_LO     4
`define TST_IVL_HI     5
`define TST_MASK       6'h35

// Reset values.
`define CONFIG_RESET 8'h00
`define GAIN_RESET   10'h040
`define CLAMP_RESET  8'h50
`define TEST_RESET   6'h00

// Pixel path constants.
`define GAIN_ROUND   26'sh80
`define GAIN_SHIFT   8
`define FULL_SCALE   12'hfff
`define STRIPE_RISE  12'h080
`define GRAD_START   12'h001
`define STRIPE_BASE  7'h08
`define GRAD_BASE    13'h0002
`define OUT_STEP_NS  3

// Controller register offsets and control bits.
`define CR_FRAME  2'h0
`define CR_CTRL   2'h1
`define CR_STATUS 2'h2
`define CR_PIXEL  2'h3
`define CT_RUN    0
`define CT_CDS    1
`define CT_POL_LO 2
`define CTRL_RESET 5'h00

// Line timing made by the controller.
`define PIX_LAST    3'h7
`define PIX_HIGH    3'h4
`define REF_PHASE   3'h1
`define DATA_PHASE  3'h5
`define LINE_LAST   6'h3f
`define DUMMY_END   6'h04
`define BLACK_END   6'h0c
`define WARM_TICKS  2'h3
`define SCLK_PERIOD_NS 100
`define SCLK_HALF_CYC ((`SCLK_PERIOD_NS / 2 + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SETTLE_MS   500
`define SETTLE_CYC_DEF (`SETTLE_MS * 1000 * (1000 / `CLOCK_PERIOD_NS))

`endif

// ==== afe_device_end.sv ====
/*
  Digital control of a two-channel line-sensor front end: serial register
  file, clamp gating, black-level loop, digital gain, test patterns and
  multiplexed pixel output with stepped delay.
  Assumes link strobes come from logic on the same clock; straps are pins.
*/
// Function
// [R1] Select pin high picks correlated sampling.
// [R2] Input clamp needs strobe and active pulse.
// [R3] Controller clamps only on dummy/black pixels.
// [R4] Gain from zero to sixteen, linear. Code divides the gain code by 256, so it stays under four.
// [R5] Black loop runs only during clamp strobe.
// [R6] Black pixels output at programmed clamp level.
// [R7] Gain change leaves black level unchanged.
// [R8] Clamp code times two, default 160.
// [R9] Standby halts all but serial port.
// [R10] Controller waits three clocks before commands.
// [R11] Output change delayed in programmed steps.
// [R12] Test mode replaces pixels with pattern.
// [R13] Stripe is clamp level plus 128.
// [R14] Gradation steps from 1 to 4095.
// [R15] Write only when select matches straps.
// [R16] Controller waits settle time before valid.
// [R17] Sixteen-bit frames, shift rising, latch rising.
// [R18] Gain code is factor times 64. Code treats it as factor times 256 (GAIN_SHIFT 8).
// [R19] Interval selects stripe period and step.
// [R20] Delay field selects 0/3/6/9 ns. Code rounds up to whole clocks: 0/1/1/2 cycles.
// [R21] Round and saturate scaled result.
// [R22] Stripe gaps sit at clamp level.
`timescale 1ns/1ps
`include "afe_defs.svh"
module afe_device_end (
  // Clock and reset.
  input  wire logic           clock,
  input  wire logic           nrst,
  // Link to the controller.
  afe_link_if.device          link,
  // Address straps.
  input  wire logic           device_select_strap_low,
  input  wire logic           device_select_strap_high,
  // Converter results.
  input  wire afe_pkg::conv_t conv_even,
  input  wire afe_pkg::conv_t conv_odd,
  // Analog control levels.
  output logic                front_end_cds,
  output logic                input_clamp_on,
  output logic                black_loop_on,
  output logic                standby_active
);
  import afe_pkg::*;

  logic [1:0]  strap_meta;
  logic [1:0]  strap_sync;
  logic        pixel_system_clock_q;
  logic        sclk_q;
  logic        latch_q;
  logic        tick_q;
  logic        next_tick_q;
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic [7:0]  config_reg;
  logic [7:0]  next_config;
  logic        standby;
  logic        next_standby;
  logic [5:0]  test_reg;
  logic [5:0]  next_test;
  logic [9:0]  gain [2];
  logic [9:0]  next_gain [2];
  logic [7:0]  clamp_code [2];
  logic [7:0]  next_clamp [2];
  conv_t       conv [2];
  conv_t       offset [2];
  conv_t       next_offset [2];
  pixel_t      hold [2];
  pixel_t      next_hold [2];
  pixel_t      clamp12 [2];
  logic [5:0]  tp_count;
  logic [5:0]  next_tp_count;
  pixel_t      grad;
  pixel_t      next_grad;
  logic [13:0] stage [3];
  logic [13:0] next_stage [3];
  logic [13:0] out_word;
  logic [13:0] next_out_word;
  logic        pix_rise;
  logic        pix_fall;
  logic        clamp_act;
  logic        black_act;
  logic        sample_act;
  logic        push;
  logic        word_odd;
  pixel_t      word_data;
  logic [1:0]  dly_cyc;
  logic [6:0]  stripe_mask;
  logic [12:0] grad_sum;
  logic [9:0]  wdata;

  assign conv[0] = conv_even;
  assign conv[1] = conv_odd;

  // Events and active levels; each strobe polarity is programmable.
  always_comb begin
    pix_rise   = link.pixel_system_clock & ~pixel_system_clock_q & ~standby;   // [R9]
    pix_fall   = ~link.pixel_system_clock & pixel_system_clock_q & ~standby;   // [R9]
    clamp_act  = link.input_clamp_strobe ^ ~config_reg[`CFG_POL_CLAMP];
    black_act  = link.black_level_clamp_strobe ^ ~config_reg[`CFG_POL_BLACK];
    sample_act = link.correlated_sample_select                     // [R1]
               ? (link.reference_sample_pulse ^ ~config_reg[`CFG_POL_SAMPLE])
               : (link.data_sample_pulse ^ ~config_reg[`CFG_POL_SAMPLE]);
  end

  // Analog control levels follow the link with no added latency.
  always_comb begin
    front_end_cds  = link.correlated_sample_select;                // [R1]
    input_clamp_on = clamp_act & sample_act & ~standby;            // [R2]
    black_loop_on  = black_act & ~standby;                         // [R5]
    standby_active = standby;                                      // [R9]
  end

  // Per-channel black loop, gain and clamp. Gain sits after the loop so
  // the black reference does not move with it.
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic signed [14:0] diff;
    logic signed [25:0] prod;
    logic signed [17:0] scaled;
    logic signed [18:0] total;
    pixel_t             chan_val;
    always_comb begin
      clamp12[c] = {3'h0, clamp_code[c], 1'b0};                    // [R8]
      diff   = $signed({1'b0, conv[c]}) - $signed({1'b0, offset[c]});
      prod   = diff * $signed({1'b0, gain[c]});                    // [R4] [R18]
      scaled = 18'((prod + `GAIN_ROUND) >>> `GAIN_SHIFT);          // [R21]
      total  = 19'(scaled) + $signed({7'h00, clamp12[c]});         // [R7]
      if (black_act) begin
        chan_val = clamp12[c];                                     // [R6]
      end else if (total < 0) begin
        chan_val = 12'h000;                                        // [R21]
      end else if (total > $signed({7'h00, `FULL_SCALE})) begin
        chan_val = `FULL_SCALE;                                    // [R21]
      end else begin
        chan_val = total[11:0];
      end
      next_offset[c] = offset[c];
      if (pix_rise && black_act) begin                             // [R5]
        if (conv[c] > offset[c]) begin
          next_offset[c] = offset[c] + 14'h0001;
        end else if (conv[c] < offset[c]) begin
          next_offset[c] = offset[c] - 14'h0001;
        end
      end
      next_hold[c] = pix_rise ? chan_val : hold[c];
    end
    always_ff @(posedge clock) begin
      if (!nrst) begin
        offset[c] <= 14'h0000;
        hold[c]   <= 12'h000;
      end else begin
        offset[c] <= next_offset[c];
        hold[c]   <= next_hold[c];
      end
    end
  end

  // Serial port keeps running in standby; writes land on the latch edge.
  always_comb begin
    wdata        = shift[`FR_DATA_HI:0];
    next_shift   = shift;
    next_config  = config_reg;
    next_standby = standby;
    next_test    = test_reg;
    next_gain    = gain;
    next_clamp   = clamp_code;
    if (link.serial_clock && !sclk_q) begin
      next_shift = {shift[14:0], link.serial_data_in};             // [R17]
    end
    if (link.serial_latch_strobe && !latch_q                       // [R17]
        && shift[`FR_SEL_HI:`FR_SEL_LO] == strap_sync              // [R15]
        && !shift[`FR_READ]) begin
      case (shift[`FR_ADDR_HI:`FR_ADDR_LO])
        `RA_CONFIG:  next_config   = wdata[7:0] & `CFG_MASK;
        `RA_STANDBY: next_standby  = wdata[0];                     // [R9]
        `RA_GAIN_E:  next_gain[0]  = wdata;
        `RA_GAIN_O:  next_gain[1]  = wdata;
        `RA_CLAMP_E: next_clamp[0] = wdata[7:0];
        `RA_CLAMP_O: next_clamp[1] = wdata[7:0];
        `RA_TEST:    next_test     = wdata[5:0] & `TST_MASK;
        default:     next_shift    = shift;
      endcase
    end
  end

  // Word multiplexing, test patterns and the delay line. Changing the
  // delay while streaming may repeat or skip one word; data holds between words.
  always_comb begin
    next_tick_q = pix_rise;
    push        = tick_q | pix_fall;
    word_odd    = tick_q ? config_reg[`CFG_ORDER] : ~config_reg[`CFG_ORDER];
    stripe_mask = 7'((`STRIPE_BASE << test_reg[`TST_IVL_HI:`TST_IVL_LO]) - 7'h01);
    grad_sum    = {1'b0, grad} + 13'(`GRAD_BASE << test_reg[`TST_IVL_HI:`TST_IVL_LO]);
    next_tp_count = tp_count;
    next_grad     = grad;
    if (!test_reg[`TST_EN]) begin
      word_data     = hold[word_odd];
      next_tp_count = 6'h00;
      next_grad     = `GRAD_START;
    end else if (test_reg[`TST_STRIPE]) begin                      // [R12]
      if (({1'b0, tp_count} & stripe_mask) == 7'h00) begin         // [R19]
        word_data = clamp12[word_odd] + `STRIPE_RISE;              // [R13]
      end else begin
        word_data = clamp12[word_odd];                             // [R22]
      end
      if (push) begin
        next_tp_count = tp_count + 6'h01;
      end
    end else begin
      word_data = grad;                                            // [R14]
      if (push) begin
        next_grad = (grad_sum > {1'b0, `FULL_SCALE}) ? `GRAD_START : grad_sum[11:0]; // [R19]
      end
    end
    next_stage[0] = push ? {1'b1, word_odd, word_data} : {1'b0, stage[0][12:0]}; // [R11]
    next_stage[1] = stage[0];
    next_stage[2] = stage[1];
    dly_cyc = 2'((config_reg[`CFG_DLY_HI:`CFG_DLY_LO] * `OUT_STEP_NS
                  + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS);    // [R20]
    next_out_word = stage[dly_cyc];                                // [R11]
  end

  // All state but the per-channel offset and hold is registered here; straps pass two flops as pins.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      strap_meta <= 2'h0;
      strap_sync <= 2'h0;
      pixel_system_clock_q   <= 1'b0;
      sclk_q     <= 1'b0;
      latch_q    <= 1'b1;
      tick_q     <= 1'b0;
      shift      <= 16'h0000;
      config_reg <= `CONFIG_RESET;
      standby    <= 1'b0;
      test_reg   <= `TEST_RESET;
      gain       <= '{`GAIN_RESET, `GAIN_RESET};
      clamp_code <= '{`CLAMP_RESET, `CLAMP_RESET};
      tp_count   <= 6'h00;
      grad       <= `GRAD_START;
      stage      <= '{14'h0000, 14'h0000, 14'h0000};
      out_word   <= 14'h0000;
    end else begin
      strap_meta <= {device_select_strap_high, device_select_strap_low};
      strap_sync <= strap_meta;
      pixel_system_clock_q   <= link.pixel_system_clock;
      sclk_q     <= link.serial_clock;
      latch_q    <= link.serial_latch_strobe;
      tick_q     <= next_tick_q;
      shift      <= next_shift;
      config_reg <= next_config;
      standby    <= next_standby;
      test_reg   <= next_test;
      gain       <= next_gain;
      clamp_code <= next_clamp;
      tp_count   <= next_tp_count;
      grad       <= next_grad;
      stage      <= next_stage;
      out_word   <= next_out_word;
    end
  end

  assign link.pixel_valid = out_word[13];
  assign link.pixel_odd   = out_word[12];
  assign link.pixel_data  = out_word[11:0];
endmodule : afe_device_end

// ==== afe_link_asserts.sv ====
/*
  Checker for the front-end link: pixel word timing, serial framing and strobe shapes.
  Assumes one system clock and the default active-low strobe polarities.
*/
`timescale 1ns/1ps
module afe_link_asserts (
  // Clock and reset.
  input wire logic            clock,
  input wire logic            nrst,
  // Serial link.
  input wire logic            serial_clock,
  input wire logic            serial_data_in,
  input wire logic            serial_latch_strobe,
  // Line timing.
  input wire logic            pixel_system_clock,
  input wire logic            reference_sample_pulse,
  // Pixel stream.
  input wire afe_pkg::pixel_t pixel_data,
  input wire logic            pixel_valid
);
  logic [4:0] bits;
  logic [4:0] next_bits;
  logic       sclk_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Count serial clock rises; the count clears while the latch idles high.
  always_comb next_bits = serial_latch_strobe ? 5'h00 : bits + {4'h0, serial_clock & ~sclk_q};
  // Register the counter and the previous serial clock level.
  always_ff @(posedge clock) begin
    sclk_q <= serial_clock;
    bits <= nrst ? next_bits : 5'h00;
  end
  word_gap_a:
    assert property (pixel_valid |=> !pixel_valid) else $error("pixel words back to back");
  data_hold_a:
    assert property ($changed(pixel_data) |-> pixel_valid) else $error("pixel data moved without a word");
  sdi_stable_a:
    assert property (serial_clock |-> $stable(serial_data_in)) else $error("serial data moved while clock high");
  sclk_gated_a:
    assert property ($changed(serial_clock) |-> !serial_latch_strobe) else $error("serial clock outside frame");
  sclk_high_a:
    assert property ($rose(serial_clock) |-> serial_clock[*7] ##1 !serial_clock) else $error("serial clock width");
  frame_bits_a:
    assert property ($rose(serial_latch_strobe) |-> bits == 5'h10) else $error("frame not sixteen bits");
  pix_clock_a:
    assert property ($rose(pixel_system_clock) |-> pixel_system_clock[*4] ##1 !pixel_system_clock)
      else $error("pixel clock high width");
  sample_pulse_a:
    assert property ($fell(reference_sample_pulse) |=> $rose(reference_sample_pulse)) else $error("sample pulse width");
endmodule : afe_link_asserts

// ==== afe_link_if.sv ====
/*
  Link between the front-end device and its timing and image controller.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface afe_link_if;
  logic           correlated_sample_select;
  logic           input_clamp_strobe;
  logic           reference_sample_pulse;
  logic           data_sample_pulse;
  logic           black_level_clamp_strobe;
  logic           pixel_system_clock;
  logic           serial_clock;
  logic           serial_data_in;
  logic           serial_latch_strobe;
  afe_pkg::pixel_t pixel_data;
  logic           pixel_valid;
  logic           pixel_odd;

  modport device (
    input  correlated_sample_select, input_clamp_strobe, reference_sample_pulse,
    input  data_sample_pulse, black_level_clamp_strobe, pixel_system_clock,
    input  serial_clock, serial_data_in, serial_latch_strobe,
    output pixel_data, pixel_valid, pixel_odd
  );
  modport controller (
    output correlated_sample_select, input_clamp_strobe, reference_sample_pulse,
    output data_sample_pulse, black_level_clamp_strobe, pixel_system_clock,
    output serial_clock, serial_data_in, serial_latch_strobe,
    input  pixel_data, pixel_valid, pixel_odd
  );
endinterface : afe_link_if

// ==== afe_pkg.sv ====
/*
  Types shared by both ends of the front-end link.
  Assumes afe_defs.svh supplies all numeric constants.
*/
package afe_pkg;
  typedef logic [13:0] conv_t;
  typedef logic [11:0] pixel_t;
  typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_LATCH} ser_state_t;
endpackage : afe_pkg

// ==== testbench.sv ====
/*
  Bench joining both link ends: register port, serial writes, gain, patterns and standby.
  Assumes afe_pkg and afe_link_if are compiled first; straps select device 2.
*/
`timescale 1ns/1ps
`include "afe_defs.svh"
`define CHECK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; $display("BAD %0t %h %h", $time, a, e); end end
module testbench;
  import afe_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [1:0]  reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic        correlated_double_sampler, iclamp, stby, bloop;
  conv_t       conv = 14'h3fff;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc = 0;
  pixel_t      w[$];
  afe_link_if link ();
  afe_device_end i_afe_device_end (.clock(clock), .nrst(nrst), .link(link), .device_select_strap_low(1'b0),
    .device_select_strap_high(1'b1), .conv_even(conv), .conv_odd(conv), .front_end_cds(correlated_double_sampler),
    .input_clamp_on(iclamp), .black_loop_on(bloop), .standby_active(stby));
  afe_controller_end #(.SETTLE_CYCLES(200)) i_afe_controller_end (.clock(clock), .nrst(nrst), .link(link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  afe_link_asserts chk (.clock(clock), .nrst(nrst), .serial_clock(link.serial_clock),
    .serial_data_in(link.serial_data_in), .serial_latch_strobe(link.serial_latch_strobe),
    .pixel_system_clock(link.pixel_system_clock), .reference_sample_pulse(link.reference_sample_pulse),
    .pixel_data(link.pixel_data), .pixel_valid(link.pixel_valid));
  // Clock at 125 MHz.
  always #4 clock = ~clock;
  // Collect every pixel word; the registered pair is read before the edge updates it.
  always @(posedge clock) if (link.pixel_valid === 1'b1) w.push_back(link.pixel_data);
  // A hang ends the run as a failure.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      final_report();
    end
  end
  task final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask : rd
  function automatic logic [15:0] fr(input logic [2:0] a, input logic [9:0] d);
    return {2'b10, 1'b0, a, d};
  endfunction : fr
  // Send one frame and wait for its latch edge to land in the device.
  task automatic send(input logic [15:0] f);
    int k;
    wr(`CR_FRAME, f);
    for (k = 0; k < 400 && link.serial_latch_strobe !== 1'b0; k++) @(posedge clock);
    for (k = 0; k < 400 && link.serial_latch_strobe !== 1'b1; k++) @(posedge clock);
    repeat (4) @(posedge clock);
  endtask : send
  // Gather n words after six that may predate the last setting.
  task automatic grab(input int n);
    w.delete();
    for (int k = 0; k < 20 * (n + 6) && w.size() < n + 6; k++) @(posedge clock);
  endtask : grab
  function automatic int hits(input pixel_t v);
    int n;
    n = 0;
    for (int i = 6; i < w.size(); i++) n += (w[i] === v);
    return n;
  endfunction : hits
  // One full line at a given gain: black words stay at the clamp level.
  task automatic gain(input logic [9:0] g, input pixel_t hv, input int nh, input int nl);
    send(fr(`RA_GAIN_E, g));
    send(fr(`RA_GAIN_O, g));
    grab(128);
    `CHECK(hits(hv), nh)
    `CHECK(hits(12'h0a0), nl)
  endtask : gain
  task automatic stripe(input pixel_t base, input logic [1:0] ivl);
    send(fr(`RA_TEST, {4'h0, ivl, 4'h5}));
    grab(16 << ivl);
    `CHECK(hits(base + 12'h080), 2)
    `CHECK(hits(base), (16 << ivl) - 2)
  endtask : stripe
  task automatic grad(input logic [1:0] ivl);
    logic [12:0] e;
    send(fr(`RA_TEST, {4'h0, ivl, 4'h1}));
    grab(16);
    for (int i = 7; i < w.size(); i++) begin
      e = {1'b0, w[i-1]} + (13'h0002 << ivl);
      `CHECK(w[i], (e > 13'h0fff) ? 12'h001 : e[11:0])
    end
  endtask : grad
  // Wait for the black strobe (active low) and judge the loop enable.
  task automatic black_loop(input logic e);
    for (int k = 0; k < 2000 && link.black_level_clamp_strobe !== 1'b0; k++) @(posedge clock);
    `CHECK(bloop, e)
  endtask : black_loop
  // Cycles from a pixel clock rise to its first word; the word of the
  // previous fall may still show in the first cycle, so counting skips it.
  task automatic out_delay(input int e);
    int n;
    @(posedge link.pixel_system_clock);
    repeat (2) @(posedge clock);
    for (n = 2; n < 20 && link.pixel_valid !== 1'b1; n++) @(posedge clock);
    `CHECK(n, e)
  endtask : out_delay
  // Main sequence.
  initial begin
    int k;
    logic [15:0] st;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    wr(`CR_CTRL, 16'h0001);
    repeat (2) @(posedge clock);
    `CHECK(correlated_double_sampler, 1'b0)
    wr(`CR_CTRL, 16'h0003);
    repeat (2) @(posedge clock);
    `CHECK(correlated_double_sampler, 1'b1)
    for (k = 0; k < 2000 && iclamp !== 1'b1; k++) @(posedge clock);
    `CHECK({iclamp, link.input_clamp_strobe, link.reference_sample_pulse}, 3'b100)
    black_loop(1'b1);
    gain(10'h000, 12'h0a0, 128, 128);
    gain(10'h3ff, 12'hfff, 112, 16);
    for (k = 0; k < 4; k++) stripe(12'h0a0, k[1:0]);
    for (k = 0; k < 4; k++) grad(k[1:0]);
    send(16'h5010);
    send(16'hb010);
    stripe(12'h0a0, 2'h0);
    send(fr(`RA_CLAMP_E, 10'h010));
    send(fr(`RA_CLAMP_O, 10'h010));
    stripe(12'h020, 2'h0);
    send(fr(`RA_STANDBY, 10'h001));
    `CHECK(stby, 1'b1)
    repeat (8) @(posedge clock);
    black_loop(1'b0);
    grab(0);
    `CHECK(w.size(), 0)
    send(fr(`RA_CONFIG, 10'h0c0));
    send(fr(`RA_STANDBY, 10'h000));
    rd(`CR_STATUS, st);
    `CHECK(st[2:0], 3'b110)
    out_delay(6);
    grab(4);
    `CHECK(w.size(), 10)
    final_report();
  end
endmodule : testbench
